// File: modem_pins_pkg.sv
// package: register offsets, bit positions and reset values of the modem pin block
package modem_pins_pkg;
    localparam int          ADDR_W          = 3;
    localparam int          DATA_W          = 8;
    // register offsets
    localparam logic [2:0]  OFS_INT_MASK    = 3'h1;
    localparam logic [2:0]  OFS_MODEM_CTRL  = 3'h4;
    localparam logic [2:0]  OFS_MODEM_STAT  = 3'h6;
    // modem control bit positions
    localparam int          MC_DTR          = 0;
    localparam int          MC_RTS          = 1;
    localparam int          MC_OUT_ONE      = 2;
    localparam int          MC_OUT_TWO      = 3;
    localparam int          MC_LOOP         = 4;
    localparam int          MC_AUTO_RTS     = 5;
    localparam int          MC_W            = 6;
    // modem status bit positions
    localparam int          MS_CTS_CHG      = 0;
    localparam int          MS_DSR_CHG      = 1;
    localparam int          MS_RING_EDGE    = 2;
    localparam int          MS_DCD_CHG      = 3;
    localparam int          MS_CTS          = 4;
    localparam int          MS_DSR          = 5;
    localparam int          MS_RING         = 6;
    localparam int          MS_DCD          = 7;
    localparam int          FLAG_W          = 4;
    // reset values
    localparam logic [5:0]  MODEM_CTRL_RST  = 6'h00;
    localparam logic [3:0]  INT_MASK_RST    = 4'h0;
    localparam logic [3:0]  FLAGS_RST       = 4'h0;
    localparam logic [3:0]  PINS_PREV_RST   = 4'hf;
    localparam logic [7:0]  READ_DATA_RST   = 8'h00;
endpackage : modem_pins_pkg

// File: modem_control_status_pins.sv
// modem control outputs, modem status inputs, change flags and host read access
`timescale 1ns/1ps
//
// What this block does
// - a set control bit 2 or 3 drives the matching user output low.
// - user outputs go high on master reset, in loop mode, or bit cleared.
// - selected and either read strobe active places addressed register on the bus.
// - status bit 6 reports the present ring indicator level.
// - status bit 2 sets only on a low-to-high ring pin transition.
// - enabled ring edge raises the interrupt toward the host.
// - control bit 1 set drives request-to-send active.
// - request-to-send goes high on master reset, in loop mode, or bit cleared.
// - auto throttling at receive threshold deasserts request-to-send over software.
// - status bits 4,5,7 hold cts, dsr, dcd; change flags in 0,1,3.
module modem_control_status_pins
    import modem_pins_pkg::*;
(
    input  wire logic              clk_sys,         // system clock, 25 MHz
    input  wire logic              reset_n,         // asynchronous reset, active low
    input  wire logic              master_reset_in, // synchronous master reset, active high
    input  wire logic              select_high_a,   // chip select, active high
    input  wire logic              select_high_b,   // chip select, active high
    input  wire logic              select_low_n,    // chip select, active low
    input  wire logic [ADDR_W-1:0] addr,            // register address
    input  wire logic [DATA_W-1:0] wdata,           // write data
    input  wire logic              write_strobe,    // one-cycle write strobe, active high
    input  wire logic              read_strobe,     // one-cycle read strobe, active high
    input  wire logic              read_strobe_n,   // one-cycle read strobe, active low
    output logic [DATA_W-1:0]      rdata,           // read data, cycle after the strobe
    input  wire logic              cts_n,           // clear to send, active low
    input  wire logic              dsr_n,           // data set ready, active low
    input  wire logic              ring_n,          // ring indicator, active low
    input  wire logic              dcd_n,           // carrier detect, active low
    input  wire logic              rx_threshold,    // receive buffer at threshold
    output logic                   dtr_n,           // data terminal ready, active low
    output logic                   rts_n,           // request to send, active low
    output logic                   user_output_one_n, // user output one, active low
    output logic                   user_output_two_n, // user output two, active low
    output logic                   irq              // interrupt, active high level
);

    // state
    logic [MC_W-1:0]   modem_control_reg, modem_control_next;
    logic [FLAG_W-1:0] int_mask_reg, int_mask_next;
    logic [FLAG_W-1:0] flags_reg, flags_next;
    logic [3:0]        pins_prev_reg, pins_prev_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic              dtr_n_reg, dtr_n_next;
    logic              rts_n_reg, rts_n_next;
    logic              out_one_n_reg, out_one_n_next;
    logic              out_two_n_reg, out_two_n_next;
    logic              irq_reg, irq_next;

    // decoded access
    logic              selected;
    logic              rd_take;
    logic              wr_take;
    logic              wr_ctrl;      // taken write to modem control
    logic              wr_mask;      // taken write to interrupt mask
    logic              rd_status;    // taken read of modem status
    logic              loop_mode;
    logic              drive_ok;     // next control value lets the pins go active
    logic              throttle;     // automatic throttling asks request-to-send off
    logic [3:0]        pins_now;     // cts, dsr, ring, dcd as seen by status (pin levels)
    logic [3:0]        level_bits;   // pin levels shown active high
    logic [FLAG_W-1:0] flag_set;
    logic [DATA_W-1:0] status_view;

    // the status byte packs four flags under four levels; refuse a package
    // edit that would break that packing or the register map
    if (FLAG_W != 4 || DATA_W != 8) begin : g_bad_flags
        $error("status byte must be eight bits, four of them flags");
    end
    if (MS_CTS != FLAG_W || MS_RING != MS_RING_EDGE + FLAG_W) begin : g_bad_layout
        $error("status levels must sit one nibble above their flags");
    end
    if (MC_W != 6 || MC_AUTO_RTS >= MC_W || MC_LOOP >= MC_W) begin : g_bad_ctrl
        $error("control bits do not fit the control register");
    end
    if (OFS_INT_MASK == OFS_MODEM_CTRL || OFS_INT_MASK == OFS_MODEM_STAT) begin : g_bad_map
        $error("register offsets overlap");
    end
    if (ADDR_W < 3) begin : g_bad_addr
        $error("address too narrow for the register map");
    end

    // bus qualification: all three selects must agree before any access counts
    always_comb begin
        selected = select_high_a & select_high_b & ~select_low_n;
        rd_take  = selected & (read_strobe | ~read_strobe_n);
        wr_take  = selected & write_strobe;
        wr_ctrl   = wr_take & (addr == OFS_MODEM_CTRL);
        wr_mask   = wr_take & (addr == OFS_INT_MASK);
        rd_status = rd_take & (addr == OFS_MODEM_STAT);
        loop_mode = modem_control_reg[MC_LOOP];
    end

    // status sources; in loop mode the control bits stand in for the modem pins
    always_comb begin
        if (loop_mode) begin
            pins_now[0] = ~modem_control_reg[MC_RTS];
            pins_now[1] = ~modem_control_reg[MC_DTR];
            pins_now[2] = ~modem_control_reg[MC_OUT_ONE];
            pins_now[3] = ~modem_control_reg[MC_OUT_TWO];
        end else begin
            pins_now[0] = cts_n;
            pins_now[1] = dsr_n;
            pins_now[2] = ring_n;
            pins_now[3] = dcd_n;
        end
    end

    // one change detector and one level bit per modem input; pins_now keeps
    // the flag order, so bit k of each lines up with no remapping
    for (genvar k = 0; k < FLAG_W; k++) begin : g_pin
        if (k == MS_RING_EDGE) begin : g_rise
            // ring counts its end only, so one ring burst is one event
            assign flag_set[k] = pins_now[k] & ~pins_prev_reg[k];
        end else begin : g_any
            // the other lines report a change either way
            assign flag_set[k] = pins_now[k] ^ pins_prev_reg[k];
        end
        assign level_bits[k] = ~pins_now[k];
    end

    // status byte: levels in the high nibble, sticky flags in the low nibble
    always_comb begin
        status_view = {level_bits, flags_reg};
    end

    // pin history: each change is judged against the level one cycle back
    always_comb begin
        pins_prev_next = pins_now;
    end

    // history ignores master reset and keeps tracking, so a pin that moves during it
    // does not count as a change once the reset is gone
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pins_prev_reg <= PINS_PREV_RST;
        end else begin
            pins_prev_reg <= pins_prev_next;
        end
    end

    // modem control: host writes land at once, master reset clears; bits
    // 7:6 of a write are dropped as no control function sits there
    always_comb begin
        modem_control_next = modem_control_reg;
        if (wr_ctrl) begin
            modem_control_next = wdata[MC_W-1:0];
        end
        if (master_reset_in) begin
            modem_control_next = MODEM_CTRL_RST;
        end
    end

    // modem control register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            modem_control_reg <= MODEM_CTRL_RST;
        end else begin
            modem_control_reg <= modem_control_next;
        end
    end

    // interrupt mask: same layout as the flags, so one and picks the
    // events that may interrupt
    always_comb begin
        int_mask_next = int_mask_reg;
        if (wr_mask) begin
            int_mask_next = wdata[FLAG_W-1:0];
        end
        if (master_reset_in) begin
            int_mask_next = INT_MASK_RST;
        end
    end

    // interrupt mask register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            int_mask_reg <= INT_MASK_RST;
        end else begin
            int_mask_reg <= int_mask_next;
        end
    end

    // change flags: sticky until the host reads the status register
    always_comb begin
        flags_next = flags_reg;
        // the read data take flags_reg, so clearing here loses nothing
        if (rd_status) begin
            flags_next = '0;
        end
        // a change in the same cycle as the clearing read still lands
        flags_next = flags_next | flag_set;
        if (master_reset_in) begin
            flags_next = FLAGS_RST;
        end
    end

    // change flag register; a flag set in the read cycle survives into
    // the next read, so no event is ever lost between two reads
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            flags_reg <= FLAGS_RST;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // read data: one cycle after a taken read, zero at every other time so
    // a bus that merges several slaves sees nothing from this one
    always_comb begin
        rdata_next = READ_DATA_RST;
        if (rd_take) begin
            case (addr)
                OFS_MODEM_CTRL: rdata_next = {2'h0, modem_control_reg};
                OFS_INT_MASK:   rdata_next = {4'h0, int_mask_reg};
                OFS_MODEM_STAT: rdata_next = status_view;
                default:        rdata_next = READ_DATA_RST;  // unmapped reads as zero
            endcase
        end
    end

    // read data register; it stands for one cycle only, so the host must
    // take it in the cycle after its strobe
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= READ_DATA_RST;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // drive terms come from the next control value, so a write shows at the
    // pins on the same edge that stores it
    always_comb begin
        drive_ok = ~modem_control_next[MC_LOOP];
        throttle = modem_control_next[MC_AUTO_RTS] & rx_threshold;
    end

    // user outputs: active only while their bit is set and loop mode is off
    always_comb begin
        out_one_n_next = ~(modem_control_next[MC_OUT_ONE] & drive_ok);
        out_two_n_next = ~(modem_control_next[MC_OUT_TWO] & drive_ok);
    end

    // user output flip-flops; reset leaves both at the inactive high level
    // that outside logic reads as off
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            out_one_n_reg <= 1'b1;
            out_two_n_reg <= 1'b1;
        end else begin
            out_one_n_reg <= out_one_n_next;
            out_two_n_reg <= out_two_n_next;
        end
    end

    // handshake outputs; throttling wins over software so the far end stops
    // sending before the receive buffer overflows
    always_comb begin
        dtr_n_next = ~(modem_control_next[MC_DTR] & drive_ok);
        rts_n_next = ~(modem_control_next[MC_RTS] & drive_ok & ~throttle);
    end

    // handshake flip-flops; reset leaves both inactive
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            dtr_n_reg <= 1'b1;
            rts_n_reg <= 1'b1;
        end else begin
            dtr_n_reg <= dtr_n_next;
            rts_n_reg <= rts_n_next;
        end
    end

    // interrupt level: any change flag whose mask bit is set; it drops on
    // the clearing read unless a new event lands in that same cycle
    always_comb begin
        irq_next = |(flags_next & int_mask_next);
    end

    // interrupt flip-flop
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    // outputs straight from flip-flops
    assign rdata             = rdata_reg;
    assign dtr_n             = dtr_n_reg;
    assign rts_n             = rts_n_reg;
    assign user_output_one_n = out_one_n_reg;
    assign user_output_two_n = out_two_n_reg;
    assign irq               = irq_reg;

endmodule : modem_control_status_pins

// File: modem_control_status_pins_props.sv
// checker: port-level properties of the modem pin block
`timescale 1ns/1ps
module modem_control_status_pins_props
    import modem_pins_pkg::*;
(
    input wire logic              clk_sys,           // system clock
    input wire logic              reset_n,           // async reset, active low
    input wire logic              master_reset_in,   // master reset
    input wire logic              select_high_a,     // select, active high
    input wire logic              select_high_b,     // select, active high
    input wire logic              select_low_n,      // select, active low
    input wire logic [ADDR_W-1:0] addr,              // register address
    input wire logic [DATA_W-1:0] wdata,             // write data
    input wire logic              write_strobe,      // write strobe
    input wire logic              read_strobe,       // read strobe, high
    input wire logic              read_strobe_n,     // read strobe, low
    input wire logic [DATA_W-1:0] rdata,             // read data
    input wire logic              cts_n,             // modem input
    input wire logic              dsr_n,             // modem input
    input wire logic              ring_n,            // modem input
    input wire logic              dcd_n,             // modem input
    input wire logic              rx_threshold,      // receive threshold
    input wire logic              rts_n,             // request to send
    input wire logic              user_output_one_n, // user output one
    input wire logic              user_output_two_n, // user output two
    input wire logic              irq                // interrupt
);
    logic       sel, rd_stat, wr, quiet, loop_reg, loop_next;
    logic [4:0] cur, h1, h2;
    assign sel     = select_high_a & select_high_b & ~select_low_n;
    assign rd_stat = sel & (read_strobe | ~read_strobe_n) & (addr == OFS_MODEM_STAT);
    assign wr      = sel & write_strobe & (addr == OFS_MODEM_CTRL);
    assign cur     = {loop_reg, dcd_n, ring_n, dsr_n, cts_n};
    // two cycles of history, so internal pin registers cannot lag a change into a read
    assign quiet   = ~wr & ~cur[4] & (cur == h1) & (h1 == h2);
    // loop mode follows control writes; master reset clears it
    always_comb begin
        loop_next = loop_reg;
        if (wr) loop_next = wdata[MC_LOOP];
        if (master_reset_in) loop_next = 1'b0;
    end
    // register the loop shadow and the pin history
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            loop_reg <= 1'b0;
            h1       <= 5'h0f;
            h2       <= 5'h0f;
        end else begin
            loop_reg <= loop_next;
            h1       <= cur;
            h2       <= h1;
        end
    end
    default clocking dflt @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    chk_out_one_level: assert property (wr && !master_reset_in |=>
        user_output_one_n == !($past(wdata[MC_OUT_ONE]) && !$past(wdata[MC_LOOP])))
        else $error("user output one wrong after control write");
    chk_out_two_level: assert property (wr && !master_reset_in |=>
        user_output_two_n == !($past(wdata[MC_OUT_TWO]) && !$past(wdata[MC_LOOP])))
        else $error("user output two wrong after control write");
    chk_rts_level: assert property (wr && !master_reset_in |=> rts_n ==
        !($past(wdata[MC_RTS]) && !$past(wdata[MC_LOOP]) &&
          !($past(wdata[MC_AUTO_RTS]) && $past(rx_threshold))))
        else $error("request to send wrong after control write");
    chk_mreset_idle: assert property (master_reset_in |=>
        rts_n && user_output_one_n && user_output_two_n)
        else $error("outputs not inactive after master reset");
    chk_rdata_idle: assert property (!(sel && (read_strobe || !read_strobe_n)) |=>
        rdata == 8'h00) else $error("read data driven without a taken read");
    chk_status_level: assert property (rd_stat && quiet |=>
        rdata[7:4] == ~$past({dcd_n, ring_n, dsr_n, cts_n}))
        else $error("status levels wrong");
    chk_flags_clear: assert property ((rd_stat && quiet) ##1 quiet ##1
        (rd_stat && quiet) |=> rdata[3:0] == 4'h0) else $error("change flags not cleared");
    chk_irq_mreset: assert property (master_reset_in ##1 !(sel && write_strobe) |=>
        !irq) else $error("interrupt up with mask cleared");
endmodule : modem_control_status_pins_props
bind modem_control_status_pins modem_control_status_pins_props u_props (.*);

// File: modem_line_model.sv
// modem side model: drives the four status pins from the bench's requests
`timescale 1ns/1ps
module modem_line_model (
    input  wire logic       clk_sys, // system clock
    input  wire logic [3:0] want,    // active request: dcd, ring, dsr, cts
    input  wire logic       slow,    // answer one cycle later
    output logic            cts_n,   // clear to send
    output logic            dsr_n,   // data set ready
    output logic            ring_n,  // ring indicator
    output logic            dcd_n    // carrier detect
);
    logic [3:0] stage = 4'hf;
    logic [3:0] drive = 4'hf;
    assign {dcd_n, ring_n, dsr_n, cts_n} = drive;
    // pins change only after an edge, like a modem clocked off the same board
    always @(posedge clk_sys) begin
        stage <= ~want;
        drive <= slow ? stage : ~want;
    end
endmodule : modem_line_model

// File: test_modem_control_status_pins.sv
// testbench: random and directed checks of the modem pin block
`timescale 1ns/1ps
module test_modem_control_status_pins;
    import modem_pins_pkg::*;
    logic              clk_sys = 1'b0, reset_n = 1'b0, master_reset_in = 1'b0, slow = 1'b0;
    logic              select_high_a = 1'b1, select_high_b = 1'b1, select_low_n = 1'b0;
    logic [ADDR_W-1:0] addr = 3'h0;
    logic [DATA_W-1:0] wdata = 8'h00, rdata, got, c, outs;
    logic              write_strobe = 1'b0, read_strobe = 1'b0, read_strobe_n = 1'b1;
    logic              cts_n, dsr_n, ring_n, dcd_n, rx_threshold = 1'b0, thr;
    logic              dtr_n, rts_n, user_output_one_n, user_output_two_n, irq;
    logic [3:0]        want = 4'h0;
    logic [31:0]       seed = 32'h0000ec31;
    logic [7:0]        corner [4] = '{8'h0e, 8'h1e, 8'h22, 8'h2e};
    int                num_errors = 0, checked = 0, cycles = 0;
    assign outs = {4'h0, dtr_n, rts_n, user_output_one_n, user_output_two_n};
    modem_control_status_pins u_dut (.*);
    modem_line_model u_modem (.*);
    initial forever #20 clk_sys = ~clk_sys;
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            num_errors++;
            wrap_up();
        end
    end
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : next_rand
    function automatic logic [7:0] exp_pins(input logic [7:0] v, input logic t);
        logic on;
        on = !v[MC_LOOP];
        return {4'h0, !(on && v[MC_DTR]), !(on && v[MC_RTS] && !(v[MC_AUTO_RTS] && t)),
                !(on && v[MC_OUT_ONE]), !(on && v[MC_OUT_TWO])};
    endfunction : exp_pins
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // one bus cycle; only one read strobe ever moves, the other stays inactive
    task automatic bus(input logic wr, input logic use_n, input logic [2:0] a,
                       input logic [7:0] d);
        @(posedge clk_sys);
        addr          <= a;
        wdata         <= d;
        write_strobe  <= wr;
        read_strobe   <= !wr && !use_n;
        read_strobe_n <= wr || !use_n;
        @(posedge clk_sys);
        write_strobe  <= 1'b0;
        read_strobe   <= 1'b0;
        read_strobe_n <= 1'b1;
        #1 got = rdata;
    endtask : bus
    task automatic set_pins(input logic [3:0] w, input int n);
        @(posedge clk_sys);
        want <= w;
        slow <= ~slow;
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : set_pins
    task automatic wrap_up();
        if (num_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        #1 chk("idle pins", 8'h0f, outs);
        for (int i = 0; i < 28; i++) begin
            seed = next_rand(seed);
            c    = (i < 4) ? corner[i] : seed[7:0];
            thr  = (i < 4) ? 1'b1 : seed[8];
            @(posedge clk_sys);
            rx_threshold <= thr;
            bus(1'b1, seed[9], OFS_MODEM_CTRL, c);
            chk("pin outputs", exp_pins(c, thr), outs);
        end
        bus(1'b1, 1'b0, OFS_MODEM_CTRL, 8'h0e);
        @(posedge clk_sys);
        master_reset_in <= 1'b1;
        @(posedge clk_sys);
        master_reset_in <= 1'b0;
        #1 chk("reset pins", 8'h0f, outs);
        set_pins(4'h0, 3);
        bus(1'b0, 1'b0, OFS_MODEM_STAT, 8'h00);
        bus(1'b1, 1'b0, OFS_INT_MASK, 8'h04);
        set_pins(4'h4, 5);
        chk("irq on ring fall", 8'h00, {7'h00, irq});
        bus(1'b0, 1'b1, OFS_MODEM_STAT, 8'h00);
        chk("ring active", 8'h40, got);
        set_pins(4'h0, 5);
        chk("irq on ring rise", 8'h01, {7'h00, irq});
        bus(1'b0, 1'b0, OFS_MODEM_STAT, 8'h00);
        chk("ring edge", 8'h04, got);
        chk("irq after read", 8'h00, {7'h00, irq});
        bus(1'b0, 1'b0, OFS_MODEM_STAT, 8'h00);
        chk("flags cleared", 8'h00, got);
        bus(1'b1, 1'b0, OFS_INT_MASK, 8'h00);
        set_pins(4'h4, 4);
        set_pins(4'h0, 5);
        chk("masked irq", 8'h00, {7'h00, irq});
        bus(1'b0, 1'b0, OFS_MODEM_STAT, 8'h00);
        set_pins(4'hb, 5);
        bus(1'b0, 1'b1, OFS_MODEM_STAT, 8'h00);
        chk("other pins", 8'hbb, got);
        set_pins(4'h0, 5);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys);
            select_high_a <= (i != 0);
            select_high_b <= (i != 1);
            select_low_n  <= (i == 2);
            bus(1'b0, i[0], OFS_MODEM_STAT, 8'h00);
            chk("unselected read", 8'h00, got);
        end
        @(posedge clk_sys);
        select_low_n <= 1'b0;
        bus(1'b0, 1'b0, OFS_MODEM_STAT, 8'h00);
        chk("flags kept", 8'h0b, got);
        bus(1'b0, 1'b1, 3'h7, 8'h00);
        chk("unmapped read", 8'h00, got);
        bus(1'b1, 1'b0, OFS_MODEM_CTRL, 8'h1f);
        chk("loop pins", 8'h0f, outs);
        bus(1'b0, 1'b0, OFS_MODEM_STAT, 8'h00);
        chk("loop status", 8'hfb, got);
        wrap_up();
    end
endmodule : test_modem_control_status_pins
